// [dpt_map.svh]
// How it works
// - pixel is 8 bits per primary
// - data bit one drives high, no inversion
// - link clock about 54 MHz, never above 67.5; here 100 MHz / 7, about 14.3 MHz
// - frame rate kept within 56 to 75 Hz; here about 11.7 to 18.7 Hz from the 14.3 MHz link clock
// - frame total 1034 to 1274 lines
// - exactly 1024 active lines per frame
// - line total 740 to 960 clocks
// - exactly 640 active clocks per line
// - both sync outputs held low
// - supply off: inputs low or high impedance
// - supply on: every signal actively driven
// - backlight on after video, off before
// - first pixel of line on odd channel
// - odd and even link clocks identical
// - data enable on lane 2 bit D26
`ifndef DPT_MAP_SVH
`define DPT_MAP_SVH

`define DPT_CLK_MHZ        32'h0000_0064
`define DPT_DIV_CYC        3'h7
`define DPT_DIV_HIGH       3'h4
`define DPT_COLOR_W        8
`define DPT_H_ACT          11'h280
`define DPT_H_TOTAL_MIN    11'h2E4
`define DPT_H_TOTAL_TYP    11'h34C
`define DPT_H_TOTAL_MAX    11'h3C0
`define DPT_H_BLANK_MIN    11'h064
`define DPT_V_ACT          11'h400
`define DPT_V_TOTAL_MIN    11'h40A
`define DPT_V_TOTAL_TYP    11'h42A
`define DPT_V_TOTAL_MAX    11'h4FA
`define DPT_V_BLANK_MIN    11'h00A
`define DPT_T_SIG_US       32'h0000_0001
`define DPT_T_BL_MS        32'h0000_0001

`endif

// [dpt_pkg.sv]
package dpt_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_PWR_UP,
        ST_VID_UP,
        ST_ON,
        ST_BL_DN,
        ST_VID_DN
    } dpt_state_e;

    typedef logic [10:0] dpt_cnt_t;
    typedef logic [23:0] dpt_pix_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic       lclk;
        logic       tick;
    } dpt_div_s;

    typedef struct packed {
        dpt_state_e  st;
        logic [31:0] wait_cnt;
        logic        run;
        dpt_cnt_t    hcnt;
        dpt_cnt_t    vcnt;
        dpt_cnt_t    htot;
        dpt_cnt_t    vtot;
        logic        vcc;
        logic        bl;
        logic        oe_n;
        logic        lclk;
        logic        de;
        logic        take;
        dpt_pix_t    odd;
        dpt_pix_t    even;
    } dpt_tcon_s;
endpackage

// [dpt_clkdiv.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dpt_map.svh"
module dpt_clkdiv
    import dpt_pkg::*;
#(
    parameter logic [2:0] DIV  = `DPT_DIV_CYC,
    parameter logic [2:0] HIGH = `DPT_DIV_HIGH
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // divided clock
    output logic      lclk_o,
    output logic      tick_o
);
    dpt_div_s q;
    dpt_div_s d;

    // link clock high for four of seven cycles
    always_comb begin
        d = q;
        d.cnt = (q.cnt == DIV - 3'h1) ? 3'h0 : q.cnt + 3'h1;
        d.lclk = (d.cnt < HIGH);
        d.tick = (d.cnt == 3'h0);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign lclk_o = q.lclk;
    assign tick_o = q.tick;
endmodule
`default_nettype wire

// [dpt_tcon.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dpt_map.svh"
module dpt_tcon
    import dpt_pkg::*;
#(
    parameter int unsigned SIG_WAIT_CYC = `DPT_T_SIG_US * `DPT_CLK_MHZ,
    parameter int unsigned BL_WAIT_CYC  = `DPT_T_BL_MS * 32'h0000_03E8 * `DPT_CLK_MHZ
) (
    // clock and reset
    input  wire logic     clk_sys_i,
    input  wire logic     rst_n_i,
    // user control
    input  wire logic     panel_on_i,
    input  wire dpt_cnt_t h_total_i,
    input  wire dpt_cnt_t v_total_i,
    // user pixels
    input  wire dpt_pix_t pix_odd_i,
    input  wire dpt_pix_t pix_even_i,
    output logic          pix_take_o,
    // panel power
    output logic          vcc_en_o,
    output logic          bl_en_o,
    // panel link
    output logic          lclk_odd_o,
    output logic          lclk_even_o,
    output dpt_pix_t      odd_data_o,
    output dpt_pix_t      even_data_o,
    output logic          de_o,
    output logic          hsync_o,
    output logic          vsync_o,
    output logic          link_oe_n_o,
    // status
    output logic          video_run_o
);
    logic      rst_meta_q;
    logic      rst_q;
    logic      div_lclk;
    logic      div_tick;
    dpt_tcon_s q;
    dpt_tcon_s d;

    // reset release through two flops
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_q      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_q      <= rst_meta_q;
        end
    end

    dpt_clkdiv u_div (
        .clk_i   (clk_sys_i),
        .rst_n_i (rst_q),
        .lclk_o  (div_lclk),
        .tick_o  (div_tick)
    );

    // clamp requested totals into the legal window
    function automatic dpt_cnt_t clamp_h(input dpt_cnt_t v);
        if (v < `DPT_H_TOTAL_MIN) begin
            clamp_h = `DPT_H_TOTAL_MIN;
        end else if (v > `DPT_H_TOTAL_MAX) begin
            clamp_h = `DPT_H_TOTAL_MAX;
        end else begin
            clamp_h = v;
        end
    endfunction

    function automatic dpt_cnt_t clamp_v(input dpt_cnt_t v);
        if (v < `DPT_V_TOTAL_MIN) begin
            clamp_v = `DPT_V_TOTAL_MIN;
        end else if (v > `DPT_V_TOTAL_MAX) begin
            clamp_v = `DPT_V_TOTAL_MAX;
        end else begin
            clamp_v = v;
        end
    endfunction

    logic     active;
    logic     line_end;
    logic     frame_end;
    dpt_cnt_t hnext;
    dpt_cnt_t vnext;

    always_comb begin
        active    = q.run && (q.hcnt < `DPT_H_ACT) && (q.vcnt < `DPT_V_ACT);
        line_end  = (q.hcnt == q.htot - 11'h001);
        frame_end = line_end && (q.vcnt == q.vtot - 11'h001);
        hnext     = line_end ? 11'h000 : q.hcnt + 11'h001;
        vnext     = frame_end ? 11'h000 : (line_end ? q.vcnt + 11'h001 : q.vcnt);
    end

    always_comb begin
        d = q;
        d.take = 1'b0;
        if (q.wait_cnt != 32'h0) begin
            d.wait_cnt = q.wait_cnt - 32'h1;
        end

        // power and backlight sequencing
        case (q.st)
            ST_OFF: begin
                if (panel_on_i) begin
                    d.vcc      = 1'b1;
                    d.oe_n     = 1'b0;
                    d.wait_cnt = SIG_WAIT_CYC;
                    d.st       = ST_PWR_UP;
                end
            end
            ST_PWR_UP: begin
                if (q.wait_cnt == 32'h0 && div_tick) begin
                    d.run      = 1'b1;
                    d.hcnt     = 11'h000;
                    d.vcnt     = 11'h000;
                    d.htot     = clamp_h(h_total_i);
                    d.vtot     = clamp_v(v_total_i);
                    d.wait_cnt = BL_WAIT_CYC;
                    d.st       = ST_VID_UP;
                end
            end
            ST_VID_UP: begin
                if (!panel_on_i) begin
                    d.wait_cnt = BL_WAIT_CYC;
                    d.st       = ST_BL_DN;
                end else if (q.wait_cnt == 32'h0) begin
                    d.bl = 1'b1;
                    d.st = ST_ON;
                end
            end
            ST_ON: begin
                if (!panel_on_i) begin
                    d.bl       = 1'b0;
                    d.wait_cnt = BL_WAIT_CYC;
                    d.st       = ST_BL_DN;
                end
            end
            ST_BL_DN: begin
                if (q.wait_cnt == 32'h0 && div_tick && frame_end) begin
                    d.run      = 1'b0;
                    d.wait_cnt = SIG_WAIT_CYC;
                    d.st       = ST_VID_DN;
                end
            end
            ST_VID_DN: begin
                if (q.wait_cnt == 32'h0) begin
                    d.vcc  = 1'b0;
                    d.oe_n = 1'b1;
                    d.st   = ST_OFF;
                end
            end
            default: begin
                d.st = ST_OFF;
            end
        endcase

        // one pixel pair per link clock
        if (div_tick) begin
            d.lclk = div_lclk && d.run;
            if (q.run) begin
                d.de   = active;
                d.take = active;
                d.odd  = active ? pix_odd_i : 24'h000000;
                d.even = active ? pix_even_i : 24'h000000;
                d.hcnt = hnext;
                d.vcnt = vnext;
                if (frame_end) begin
                    d.htot = clamp_h(h_total_i);
                    d.vtot = clamp_v(v_total_i);
                end
            end
        end else begin
            d.lclk = div_lclk && q.run;
        end
        if (!d.run && !q.run) begin
            d.de   = 1'b0;
            d.odd  = 24'h000000;
            d.even = 24'h000000;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_q) begin
        if (!rst_q) begin
            q      <= '0;
            q.st   <= ST_OFF;
            q.oe_n <= 1'b1;
            q.htot <= `DPT_H_TOTAL_TYP;
            q.vtot <= `DPT_V_TOTAL_TYP;
        end else begin
            q <= d;
        end
    end

    assign pix_take_o  = q.take;
    assign vcc_en_o    = q.vcc;
    assign bl_en_o     = q.bl;
    assign lclk_odd_o  = q.lclk;
    assign lclk_even_o = q.lclk;
    assign odd_data_o  = q.odd;
    assign even_data_o = q.even;
    assign de_o        = q.de;
    assign hsync_o     = 1'b0;
    assign vsync_o     = 1'b0;
    assign link_oe_n_o = q.oe_n;
    assign video_run_o = q.run;

    // helper counters for checks
    logic [12:0] de_len_q;
    logic [12:0] blank_len_q;
    always_ff @(posedge clk_sys_i or negedge rst_q) begin
        if (!rst_q) begin
            de_len_q    <= 13'h0000;
            blank_len_q <= 13'h0000;
        end else begin
            de_len_q    <= de_o ? de_len_q + 13'h0001 : 13'h0000;
            blank_len_q <= de_o ? 13'h0000 : blank_len_q + {12'h000, ~&blank_len_q};
        end
    end

    // set once data enable has been high since video start
    logic line_seen_q;
    always_ff @(posedge clk_sys_i or negedge rst_q) begin
        if (!rst_q) begin
            line_seen_q <= 1'b0;
        end else begin
            line_seen_q <= video_run_o && (line_seen_q || de_o);
        end
    end

    a_sync_low: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        !hsync_o && !vsync_o)
        else $error("sync output not low");

    a_de_width: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        $fell(de_o) |-> de_len_q == 13'h1180)
        else $error("active line not 640 link clocks");

    a_hblank_min: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        $rose(de_o) && line_seen_q |-> blank_len_q >= 13'h02BC)
        else $error("horizontal blanking too short");

    a_lclk_duty: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        $rose(lclk_odd_o) |-> lclk_odd_o[*4] ##1 !lclk_odd_o[*3])
        else $error("link clock duty not 4/7");

    a_bl_order: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        bl_en_o |-> vcc_en_o && video_run_o)
        else $error("backlight on without video");

    a_off_quiet: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        !vcc_en_o |-> !de_o && !lclk_odd_o && odd_data_o == 24'h0 && even_data_o == 24'h0)
        else $error("link not quiet with supply off");

    a_on_driven: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        vcc_en_o |-> !link_oe_n_o)
        else $error("link released while supply on");

    a_totals_legal: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        q.vtot >= `DPT_V_TOTAL_MIN && q.vtot <= `DPT_V_TOTAL_MAX
        && q.htot >= `DPT_H_TOTAL_MIN && q.htot <= `DPT_H_TOTAL_MAX)
        else $error("line or frame total out of range");

    a_de_active: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        div_tick && q.run && (q.vcnt >= `DPT_V_ACT) |=> !de_o)
        else $error("data enable in vertical blanking");

    a_take_at_start: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        $rose(de_o) |-> pix_take_o)
        else $error("no pixel taken at line start");

    a_blank_zero: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        !de_o |-> odd_data_o == 24'h000000 && even_data_o == 24'h000000)
        else $error("pixel data not zero while data enable low");

    a_de_on_edge: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        $changed(de_o) |-> $rose(lclk_odd_o))
        else $error("data enable moved off a link clock edge");

    a_run_powered: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        video_run_o |-> vcc_en_o && !link_oe_n_o)
        else $error("video running without supply or drive");

    a_pos_range: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        q.hcnt < q.htot && q.vcnt < q.vtot)
        else $error("position counter beyond its total");

    a_lclk_idle: assert property (
        @(posedge clk_sys_i) disable iff (!rst_q)
        !video_run_o |-> !lclk_odd_o)
        else $error("link clock running while video stopped");
endmodule
`default_nettype wire

// [dpt_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
module dpt_panel_model
    import dpt_pkg::*;
(
    // link from the controller
    input  wire logic     lclk_odd_i,
    input  wire logic     lclk_even_i,
    input  wire dpt_pix_t odd_i,
    input  wire dpt_pix_t even_i,
    input  wire logic     de_i,
    input  wire logic     hsync_i,
    input  wire logic     vsync_i,
    // observed timing
    output logic [15:0]   line_len_o,
    output logic [15:0]   act_len_o,
    output logic [15:0]   lines_o,
    output dpt_pix_t      first_odd_o,
    output dpt_pix_t      first_even_o,
    output logic [9:0]    luma_o,
    output logic          fault_o
);
    logic [15:0] gap;
    logic [15:0] act;
    logic        de_q;

    initial begin
        {line_len_o, act_len_o, lines_o, gap, act, de_q} = '0;
        {first_odd_o, first_even_o, luma_o, fault_o} = '0;
    end

    // both link clocks seen one step after each edge
    always @(lclk_odd_i) begin
        #1;
        if (lclk_even_i !== lclk_odd_i) fault_o <= 1'b1;
    end

    // data taken mid-period, on the falling link clock edge
    always @(negedge lclk_odd_i) begin
        luma_o <= 10'(odd_i[23:16]) + 10'(odd_i[15:8]) + 10'(odd_i[7:0]);
        if (hsync_i !== 1'b0 || vsync_i !== 1'b0) fault_o <= 1'b1;
        if (!de_i && (odd_i != '0 || even_i != '0)) fault_o <= 1'b1;
        if (de_i && !de_q) begin
            line_len_o   <= gap;
            gap          <= 16'h0001;
            lines_o      <= lines_o + 16'h0001;
            first_odd_o  <= odd_i;
            first_even_o <= even_i;
        end else begin
            gap <= gap + 16'h0001;
        end
        if (de_i) act <= de_q ? act + 16'h0001 : 16'h0001;
        if (!de_i && de_q) act_len_o <= act;
        de_q <= de_i;
    end
endmodule
`default_nettype wire

// [dpt_tcon_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module dpt_tcon_tb
    import dpt_pkg::*;
;
    logic        clk_sys_i;
    logic        rst_n_i;
    logic        panel_on_i;
    logic [15:0] idx;
    logic        pix_take_o, vcc_en_o, bl_en_o, lclk_odd_o, lclk_even_o;
    logic        de_o, hsync_o, vsync_o, link_oe_n_o, video_run_o, fault;
    dpt_pix_t    odd_data_o, even_data_o, first_odd, first_even;
    logic [15:0] line_len, act_len, lines;
    logic [9:0]  luma;
    int          num_errors, total_checks;

    // line total below minimum, clamped to 740
    dpt_tcon #(.SIG_WAIT_CYC(2), .BL_WAIT_CYC(20)) u_dpt_tcon (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .panel_on_i(panel_on_i),
        .h_total_i(11'h2BC), .v_total_i(11'h42A),
        .pix_odd_i({8'hC3, idx}), .pix_even_i({8'h3C, idx}), .pix_take_o(pix_take_o),
        .vcc_en_o(vcc_en_o), .bl_en_o(bl_en_o), .lclk_odd_o(lclk_odd_o),
        .lclk_even_o(lclk_even_o), .odd_data_o(odd_data_o), .even_data_o(even_data_o),
        .de_o(de_o), .hsync_o(hsync_o), .vsync_o(vsync_o), .link_oe_n_o(link_oe_n_o),
        .video_run_o(video_run_o));

    dpt_panel_model u_dpt_panel_model (
        .lclk_odd_i(lclk_odd_o), .lclk_even_i(lclk_even_o), .odd_i(odd_data_o),
        .even_i(even_data_o), .de_i(de_o), .hsync_i(hsync_o), .vsync_i(vsync_o),
        .line_len_o(line_len), .act_len_o(act_len), .lines_o(lines),
        .first_odd_o(first_odd), .first_even_o(first_even), .luma_o(luma), .fault_o(fault));

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // next pixel pair after each take
    always @(negedge clk_sys_i) if (pix_take_o === 1'b1) idx <= idx + 16'h0001;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic bound_hit(input int n, input int lim);
        if (n >= lim) begin
            num_errors++;
            complete_run();
        end
    endtask

    task automatic t_power_up;
        int n;
        n = 0;
        panel_on_i = 1'b1;
        while (vcc_en_o !== 1'b1 && n < 4) begin @(negedge clk_sys_i); n++; end
        bound_hit(n, 4);
        check({vcc_en_o, link_oe_n_o}, 2'b10);
        n = 0;
        while (video_run_o !== 1'b1 && n < 20) begin @(negedge clk_sys_i); n++; end
        bound_hit(n, 20);
        check(bl_en_o, 1'b0);
        check({hsync_o, vsync_o}, 2'b00);
        n = 0;
        while (bl_en_o !== 1'b1 && n < 40) begin @(negedge clk_sys_i); n++; end
        bound_hit(n, 40);
        check(n >= 20 && n <= 22, 1'b1);
        $display("test power up done");
    endtask

    task automatic t_lclk;
        int hi, lo, n;
        {hi, lo, n} = '0;
        while (lclk_odd_o !== 1'b0 && n < 50) begin @(posedge clk_sys_i); #1; n++; end
        while (lclk_odd_o !== 1'b1 && n < 50) begin @(posedge clk_sys_i); #1; n++; end
        while (lclk_odd_o === 1'b1 && n < 50) begin @(posedge clk_sys_i); #1; n++; hi++; end
        while (lclk_odd_o === 1'b0 && n < 50) begin @(posedge clk_sys_i); #1; n++; lo++; end
        bound_hit(n, 50);
        check(hi, 4);
        check(lo, 3);
        $display("test link clock done");
    endtask

    task automatic t_line;
        int n;
        n = 0;
        while (lines < 16'h0002 && n < 12000) begin @(negedge clk_sys_i); n++; end
        bound_hit(n, 12000);
        check(line_len, 740);
        check(act_len, 640);
        check(line_len - act_len, 100);
        check(first_odd, {8'hC3, 16'h0280});
        check(first_even, {8'h3C, 16'h0280});
        check(luma, 10'h145);
        check(fault, 1'b0);
        $display("test line timing done");
    endtask

    task automatic t_power_down;
        int n;
        n = 0;
        panel_on_i = 1'b0;
        while (bl_en_o !== 1'b0 && n < 3) begin @(negedge clk_sys_i); n++; end
        bound_hit(n, 3);
        check({vcc_en_o, video_run_o, link_oe_n_o}, 3'b110);
        $display("test power down done");
    endtask

    task automatic t_reset_mid;
        rst_n_i = 1'b0;
        @(negedge clk_sys_i);
        check({vcc_en_o, bl_en_o, de_o, video_run_o, lclk_odd_o, link_oe_n_o}, 6'h01);
        check({odd_data_o, even_data_o} == 48'h0, 1'b1);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        check({vcc_en_o, bl_en_o, de_o, video_run_o, lclk_odd_o, link_oe_n_o}, 6'h01);
        check(fault, 1'b0);
        $display("test reset in run done");
    endtask

    initial begin
        {num_errors, total_checks} = '0;
        rst_n_i = 1'b0;
        panel_on_i = 1'b0;
        idx = 16'h0000;
        repeat (16) @(negedge clk_sys_i);
        check({vcc_en_o, bl_en_o, de_o, video_run_o, link_oe_n_o}, 5'b00001);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        t_power_up();
        t_lclk();
        t_line();
        t_power_down();
        t_reset_mid();
        t_power_up();
        complete_run();
    end
endmodule
`default_nettype wire
